/* hdl/rx_classifier_defs.vh */
// constants for the receive packet classifier: cam geometry, control word layout,
// action codes and default rule set anchors
// assumes it is included by the classifier design file and by the self-checking bench
`ifndef RX_CLASSIFIER_DEFS_VH
`define RX_CLASSIFIER_DEFS_VH

// ----------------------------------------
// cam geometry
// ----------------------------------------
`define CAM_DEPTH 128
`define CAM_ADDR_W 7
`define CAM_WORD_W 15
`define CAM_BYTE_W 8
`define CTRL_W 14
`define LOOP_W 5
`define ENTRY_NEVER 7'h00
`define ENTRY_ALWAYS 7'h01

// ----------------------------------------
// control word fields
// ----------------------------------------
`define CTRL_OPERAND_LSB 0
`define CTRL_ACTION_LSB 8
`define CTRL_IRQ_BIT 12
`define CTRL_DROP_BIT 13

// match control values
`define MC_PASS_ON_MATCH 1'b0
`define MC_DROP 1'b1

// ----------------------------------------
// action codes
// ----------------------------------------
`define ACT_NOP 4'h0
`define ACT_PAUSE_HI 4'h1
`define ACT_PAUSE_LO 4'h2
`define ACT_PAUSE_START 4'h3
`define ACT_WAKE 4'h4
`define ACT_SET_RESULT 4'h5
`define ACT_SET_MC 4'h6
`define ACT_SET_BC 4'h7
`define ACT_MARK_LENTYPE 4'h8
`define ACT_MARK_IPHDR 4'h9
`define ACT_LOAD_X_BYTE 4'ha
`define ACT_KEEP_SCRATCH 4'hb
`define ACT_LOAD_LOOP_COUNT 4'hc
`define ACT_LOOP_COUNT_DOWN 4'hd
`define ACT_USE_X 4'he
`define ACT_DONE 4'hf

// ----------------------------------------
// default rule set: first rule of each address byte stage
// ----------------------------------------
`define UC_BYTE0_BASE 7'h70
`define UC_BYTE1_BASE 7'h68
`define UC_BYTE2_BASE 7'h58
`define UC_BYTE3_BASE 7'h50
`define UC_BYTE4_BASE 7'h40
`define UC_BYTE5_BASE 7'h30
`define MCF_BYTE0_BASE 7'h7c
`define MCF_BYTE1_BASE 7'h64
`define MCF_BYTE2_BASE 7'h60
`define MCF_BYTE3_BASE 7'h4c
`define MCF_BYTE4_BASE 7'h48
`define MCF_BYTE5_BASE 7'h3c
`define PREV_MASK_ON 7'h7f
`define PAUSE_FILTER_ADDR 48'h0180c2000001
`define BCAST_FILTER_ADDR 48'hffffffffffff

`endif

/* hdl/rx_packet_classifier_cam.v */
// receive packet classifier: 128-entry ternary cam chained to a byte sequencer
// assumes the receive byte stream is on i_core_clk; rules are written through a plain
// rule port after the reset load has finished (o_ready high)
//
// Functional notes
// - cam has 128 entries of 15-bit data compared against a 15-bit reference
// - several matches report the highest numbered matching entry
// - each entry has 15 mask bits; a cleared bit is excluded from compare
// - entry 0 never matches, so no lookup yields zero
// - entry 1 always matches, so an unmatched reference yields one
// - each entry has a control word handed to the sequencer
// - reference word is 7-bit previous hit joined to frame byte or scratch
// - previous hit and scratch byte start each frame at zero
// - lookups repeat per byte until frame end or completion; result is last hit
// - actions load pause counter high and low bytes and start pause timer
// - actions drop frame, interrupt host, start notify timer, alter result
// - actions tag multicast/broadcast, mark length/type and ip header
// - 8-bit scratch byte loads from frame byte or cam result
// - 5-bit loop tally set by load action, decremented by count-down action
// - tally expiry uses executing rule address minus one as previous hit
// - reset loads default rules: four multicast, eight unicast, promiscuous on
// - rule 0x30 set to drop leaves promiscuous mode
// - rule 0x30 set back to pass-on-match re-enters promiscuous mode
// - unicast filter n uses rules 0x70,0x68,0x58,0x50,0x40,0x30 plus n
// - address filters compare 48-bit destination under per-bit wildcard mask
`timescale 1ns/1ns
`include "rx_classifier_defs.vh"

module rx_packet_classifier_cam #(
    parameter DEPTH = `CAM_DEPTH
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_rx_valid,
    input wire i_rx_sof,
    input wire i_rx_eof,
    input wire [7:0] i_rx_data,
    input wire i_rule_wr,
    input wire [6:0] i_rule_index_select,
    input wire [29:0] i_rule_match_word,
    input wire [13:0] i_rule_action_word,
    output reg o_ready,
    output reg o_frame_done,
    output reg [6:0] o_rx_packet_status_reg,
    output reg o_drop,
    output reg o_mcast,
    output reg o_bcast,
    output reg o_irq,
    output reg o_host_notify_timer_start,
    output reg [15:0] o_pause_value,
    output reg o_pause_start,
    output reg o_lentype_mark,
    output reg o_iphdr_mark
);

// ----------------------------------------
// state and storage
// ----------------------------------------
localparam ST_INIT = 2'b00;
localparam ST_IDLE = 2'b01;
localparam ST_RUN = 2'b10;
localparam ST_HOLD = 2'b11;

reg [1:0] state;
reg [6:0] init_idx;
reg [`CAM_WORD_W-1:0] cam_data [0:DEPTH-1];
reg [`CAM_WORD_W-1:0] cam_mask [0:DEPTH-1];
reg [`CTRL_W-1:0] cam_ctrl [0:DEPTH-1];
reg [6:0] prev_hit;
reg [7:0] scratch;
reg use_scratch;
reg [`LOOP_W-1:0] loop_tally;
reg [6:0] result;
reg drop_flag;
reg mc_flag;
reg bc_flag;

wire [DEPTH-1:0] match_vec;
wire [`CAM_WORD_W-1:0] ref_word;
wire [6:0] ref_prev;
wire [7:0] ref_byte;
wire take_byte;
wire [`CTRL_W-1:0] ctrl;
wire [3:0] action;
wire [7:0] operand;
wire [43:0] init_rule;
reg [6:0] hit;
integer k;

// ----------------------------------------
// default rule set
// ----------------------------------------
// byte k of a 48-bit address, byte 0 first on the wire
function [7:0] addr_byte;
    input [47:0] addr;
    input [2:0] idx;
    begin
        addr_byte = addr[47 - idx * 8 -: 8];
    end
endfunction

// returns {ctrl, mask, data} for entry idx after reset
function [43:0] default_rule;
    input [6:0] idx;
    reg [2:0] n;
    reg [2:0] stage;
    reg fam_uc;
    reg fam_mc;
    reg [6:0] prev_base;
    reg [47:0] faddr;
    reg [47:0] fmask;
    reg live;
    reg [3:0] act;
    begin
        fam_uc = 1'b1;
        fam_mc = 1'b0;
        stage = 3'd0;
        prev_base = 7'h00;
        case (idx[6:3])
            4'he: stage = 3'd0;
            4'hd: begin stage = 3'd1; prev_base = `UC_BYTE0_BASE; end
            4'hb: begin stage = 3'd2; prev_base = `UC_BYTE1_BASE; end
            4'ha: begin stage = 3'd3; prev_base = `UC_BYTE2_BASE; end
            4'h8: begin stage = 3'd4; prev_base = `UC_BYTE3_BASE; end
            4'h6: begin stage = 3'd5; prev_base = `UC_BYTE4_BASE; end
            default: fam_uc = 1'b0;
        endcase
        if (!fam_uc) begin
            fam_mc = 1'b1;
            case (idx[6:2])
                5'h1f: stage = 3'd0;
                5'h19: begin stage = 3'd1; prev_base = `MCF_BYTE0_BASE; end
                5'h18: begin stage = 3'd2; prev_base = `MCF_BYTE1_BASE; end
                5'h13: begin stage = 3'd3; prev_base = `MCF_BYTE2_BASE; end
                5'h12: begin stage = 3'd4; prev_base = `MCF_BYTE3_BASE; end
                5'h0f: begin stage = 3'd5; prev_base = `MCF_BYTE4_BASE; end
                default: fam_mc = 1'b0;
            endcase
        end
        n = fam_uc ? idx[2:0] : {1'b0, idx[1:0]};
        // unicast #0 is all wildcard; multicast #0 only needs the group bit
        faddr = 48'h0;
        fmask = 48'h0;
        live = 1'b0;
        act = `ACT_NOP;
        if (fam_uc) begin
            live = (n == 3'd0);
        end else if (fam_mc) begin
            live = (n != 3'd2);
            act = (stage == 3'd0) ? ((n == 3'd3) ? `ACT_SET_BC : `ACT_SET_MC) : `ACT_NOP;
            if (n == 3'd0) begin
                faddr = 48'h010000000000;
                fmask = 48'h010000000000;
            end else if (n == 3'd1) begin
                faddr = `PAUSE_FILTER_ADDR;
                fmask = 48'hffffffffffff;
            end else begin
                faddr = `BCAST_FILTER_ADDR;
                fmask = 48'hffffffffffff;
            end
        end
        if (stage == 3'd5)
            act = `ACT_KEEP_SCRATCH;
        if (!(fam_uc || fam_mc)) begin
            // unused entry: waits on itself as previous hit, so it never fires
            default_rule = {{`CTRL_W{1'b0}}, {`PREV_MASK_ON, 8'hff}, {idx, 8'h00}};
        end else if (stage == 3'd0) begin
            // byte 0 rule: enabled by previous hit mask, disabled by self reference
            default_rule = {{1'b0, 1'b0, act, 8'h00},
                            {`PREV_MASK_ON, addr_byte(fmask, 3'd0)},
                            {live ? 7'h00 : idx, addr_byte(faddr, 3'd0)}};
        end else begin
            default_rule = {{1'b0, 1'b0, act, 8'h00},
                            {`PREV_MASK_ON, addr_byte(fmask, stage)},
                            {prev_base + {4'h0, n}, addr_byte(faddr, stage)}};
        end
    end
endfunction

assign init_rule = default_rule(init_idx);

// ----------------------------------------
// rule memory: reset load walk, then software writes
// ----------------------------------------
always @(posedge i_core_clk) begin
    if (state == ST_INIT) begin
        cam_ctrl[init_idx] <= init_rule[43:30];
        cam_mask[init_idx] <= init_rule[29:15];
        cam_data[init_idx] <= init_rule[14:0];
    end else if (i_rule_wr) begin
        cam_ctrl[i_rule_index_select] <= i_rule_action_word;
        cam_mask[i_rule_index_select] <= i_rule_match_word[29:15];
        cam_data[i_rule_index_select] <= i_rule_match_word[14:0];
    end
end

// ----------------------------------------
// ternary compare and priority
// ----------------------------------------
assign take_byte = i_rx_valid && ((state == ST_IDLE && i_rx_sof) || (state == ST_RUN));
assign ref_prev = (state != ST_RUN || i_rx_sof) ? 7'h00 : prev_hit;
assign ref_byte = (state == ST_RUN && !i_rx_sof && use_scratch) ? scratch : i_rx_data;
assign ref_word = {ref_prev, ref_byte};

// per-entry compare; cleared mask bits cannot block a match
genvar g;
generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_cmp
        assign match_vec[g] = (((cam_data[g] ^ ref_word) & cam_mask[g]) == 15'h0000);
    end
endgenerate

// highest entry wins; entry 0 is skipped and entry 1 is the floor
always @* begin
    hit = `ENTRY_ALWAYS;
    for (k = 2; k < DEPTH; k = k + 1) begin
        if (match_vec[k])
            hit = k[6:0];
    end
end

assign ctrl = cam_ctrl[hit];
assign action = ctrl[`CTRL_ACTION_LSB +: 4];
assign operand = ctrl[`CTRL_OPERAND_LSB +: 8];

// ----------------------------------------
// sequencer
// ----------------------------------------
// one lookup and one action per byte; state advances on every accepted byte
always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
        state <= ST_INIT;
        init_idx <= 7'h00;
        o_ready <= 1'b0;
        prev_hit <= 7'h00;
        scratch <= 8'h00;
        use_scratch <= 1'b0;
        loop_tally <= 5'h00;
        result <= 7'h00;
        drop_flag <= 1'b0;
        mc_flag <= 1'b0;
        bc_flag <= 1'b0;
        o_frame_done <= 1'b0;
        o_rx_packet_status_reg <= 7'h00;
        o_drop <= 1'b0;
        o_mcast <= 1'b0;
        o_bcast <= 1'b0;
        o_irq <= 1'b0;
        o_host_notify_timer_start <= 1'b0;
        o_pause_value <= 16'h0000;
        o_pause_start <= 1'b0;
        o_lentype_mark <= 1'b0;
        o_iphdr_mark <= 1'b0;
    end else begin
        o_frame_done <= 1'b0;
        o_irq <= 1'b0;
        o_host_notify_timer_start <= 1'b0;
        o_pause_start <= 1'b0;
        o_lentype_mark <= 1'b0;
        o_iphdr_mark <= 1'b0;
        case (state)
            ST_INIT: begin
                init_idx <= init_idx + 7'h01;
                if (init_idx == 7'h7f) begin
                    state <= ST_IDLE;
                    o_ready <= 1'b1;
                end
            end
            ST_IDLE, ST_RUN: begin
                if (take_byte) begin
                    // a new frame clears the per-frame context before its first action
                    if (i_rx_sof) begin
                        scratch <= 8'h00;
                        use_scratch <= 1'b0;
                        loop_tally <= 5'h00;
                        drop_flag <= ctrl[`CTRL_DROP_BIT];
                        mc_flag <= (action == `ACT_SET_MC);
                        bc_flag <= (action == `ACT_SET_BC);
                    end else begin
                        drop_flag <= drop_flag | ctrl[`CTRL_DROP_BIT];
                        mc_flag <= mc_flag | (action == `ACT_SET_MC);
                        bc_flag <= bc_flag | (action == `ACT_SET_BC);
                        use_scratch <= 1'b0;
                    end
                    prev_hit <= hit;
                    result <= hit;
                    o_irq <= ctrl[`CTRL_IRQ_BIT];
                    state <= ST_RUN;
                    case (action)
                        `ACT_PAUSE_HI: o_pause_value[15:8] <= i_rx_data;
                        `ACT_PAUSE_LO: o_pause_value[7:0] <= i_rx_data;
                        `ACT_PAUSE_START: o_pause_start <= 1'b1;
                        `ACT_WAKE: o_host_notify_timer_start <= 1'b1;
                        `ACT_SET_RESULT: result <= operand[6:0];
                        `ACT_MARK_LENTYPE: o_lentype_mark <= 1'b1;
                        `ACT_MARK_IPHDR: o_iphdr_mark <= 1'b1;
                        `ACT_LOAD_X_BYTE: scratch <= i_rx_data;
                        `ACT_KEEP_SCRATCH: begin
                            scratch <= {1'b0, hit};
                            state <= ST_HOLD;
                        end
                        `ACT_LOAD_LOOP_COUNT: loop_tally <= operand[4:0];
                        `ACT_LOOP_COUNT_DOWN: begin
                            loop_tally <= (loop_tally == 5'h00) ? 5'h00 : loop_tally - 5'h01;
                            if (loop_tally <= 5'h01)
                                prev_hit <= hit - 7'h01;
                        end
                        `ACT_USE_X: use_scratch <= 1'b1;
                        `ACT_DONE: state <= ST_HOLD;
                        default: begin
                        end
                    endcase
                    if (i_rx_eof)
                        state <= ST_IDLE;
                end
                // report once the last byte has been acted on
                if (state == ST_RUN && i_rx_valid && i_rx_eof) begin
                    o_frame_done <= 1'b1;
                    o_rx_packet_status_reg <= (action == `ACT_SET_RESULT) ? operand[6:0] : hit;
                    o_drop <= drop_flag | ctrl[`CTRL_DROP_BIT];
                    o_mcast <= mc_flag | (action == `ACT_SET_MC);
                    o_bcast <= bc_flag | (action == `ACT_SET_BC);
                end else if (state == ST_IDLE && take_byte && i_rx_eof) begin
                    o_frame_done <= 1'b1;
                    o_rx_packet_status_reg <= (action == `ACT_SET_RESULT) ? operand[6:0] : hit;
                    o_drop <= ctrl[`CTRL_DROP_BIT];
                    o_mcast <= (action == `ACT_SET_MC);
                    o_bcast <= (action == `ACT_SET_BC);
                end
            end
            ST_HOLD: begin
                // classification is complete; remaining bytes are ignored
                if (i_rx_valid && i_rx_eof) begin
                    state <= ST_IDLE;
                    o_frame_done <= 1'b1;
                    o_rx_packet_status_reg <= result;
                    o_drop <= drop_flag;
                    o_mcast <= mc_flag;
                    o_bcast <= bc_flag;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule // rx_packet_classifier_cam

/* verif/rx_byte_source.sv */
// receive byte stream source standing in for the mac receive path
// assumes one clock shared with the classifier; frames are sent by hierarchical task call
`timescale 1ns/1ns

module rx_byte_source (
    input wire logic i_core_clk,
    output logic o_valid,
    output logic o_sof,
    output logic o_eof,
    output logic [7:0] o_data
);
    // idle lines at time zero
    initial begin
        o_valid = 1'b0;
        o_sof = 1'b0;
        o_eof = 1'b0;
        o_data = 8'h00;
    end

    // one byte per cycle, sof on byte 0, eof on the last byte
    task automatic send(input logic [7:0] b [0:7], input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_core_clk);
            o_valid <= 1'b1;
            o_sof <= (i == 0);
            o_eof <= (i == n - 1);
            o_data <= b[i];
        end
        @(posedge i_core_clk);
        o_valid <= 1'b0;
        o_sof <= 1'b0;
        o_eof <= 1'b0;
        o_data <= ~b[n - 1]; // released data must not look like the last byte
    endtask
endmodule // rx_byte_source

/* verif/rx_packet_classifier_cam_sva.sv */
// checker for the receive packet classifier, port level only
// assumes one clock and the asynchronous active high reset of the design
`timescale 1ns/1ns

module rx_packet_classifier_cam_sva (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_rx_valid,
    input wire i_rx_eof,
    input wire o_ready,
    input wire o_frame_done,
    input wire [6:0] o_rx_packet_status_reg,
    input wire o_drop,
    input wire o_irq,
    input wire [15:0] o_pause_value
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // counts edges spent in the reset load walk
    logic [7:0] cnt;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst)
            cnt <= 8'h00;
        else if (!o_ready)
            cnt <= cnt + 8'h01;
    end

    AST_READY_AT: assert property (!o_ready && cnt == 8'd127 |=> o_ready)
        else $error("ready not raised on edge 128 after reset");
    AST_READY_MAX: assert property (!o_ready |-> cnt < 8'd128)
        else $error("reset load walk too long");
    AST_READY_HOLD: assert property (o_ready |=> o_ready)
        else $error("ready dropped");
    AST_QUIET: assert property (!o_ready |-> !o_frame_done && !o_irq && !o_drop)
        else $error("activity before ready");
    AST_NONZERO: assert property (o_frame_done |-> o_rx_packet_status_reg != 7'h00)
        else $error("zero classification result");
    AST_DONE_CAUSE: assert property (o_frame_done |-> $past(i_rx_eof) && $past(i_rx_valid))
        else $error("frame done without a last byte");
    AST_RESULT_HELD: assert property (!o_frame_done |-> $stable(o_rx_packet_status_reg))
        else $error("result changed outside frame done");
    AST_DROP_HELD: assert property (!o_frame_done |-> $stable(o_drop))
        else $error("drop changed outside frame done");
    AST_IRQ_CAUSE: assert property (o_irq |-> $past(i_rx_valid))
        else $error("interrupt without a byte");
    AST_PAUSE_CAUSE: assert property (!$stable(o_pause_value) |-> $past(i_rx_valid))
        else $error("pause value changed without a byte");
endmodule // rx_packet_classifier_cam_sva

bind rx_packet_classifier_cam rx_packet_classifier_cam_sva u_sva (.i_core_clk, .i_rst, .i_rx_valid,
    .i_rx_eof, .o_ready, .o_frame_done, .o_rx_packet_status_reg, .o_drop, .o_irq, .o_pause_value);

/* verif/rx_packet_classifier_cam_tb.sv */
// self-checking bench for the receive packet classifier
// assumes the design and rx_byte_source are compiled first; expected verdicts queue up per frame
`timescale 1ns/1ns
`include "rx_classifier_defs.vh"

module rx_packet_classifier_cam_tb;
    logic i_core_clk, i_rst, i_rule_wr;
    logic [6:0] i_rule_index_select;
    logic [29:0] i_rule_match_word;
    logic [13:0] i_rule_action_word;
    wire v, s, e, o_ready, o_frame_done, o_drop, o_irq;
    wire [7:0] d;
    wire [6:0] o_rx_packet_status_reg;
    wire [15:0] o_pause_value;
    wire o_mcast, o_bcast, o_host_notify_timer_start, o_pause_start, o_lentype_mark, o_iphdr_mark;
    logic [9:0] exp_q [$];
    logic [1:0] exp_mb = 2'b00;
    logic [15:0] n_pulse = 16'h0000;
    logic [7:0] fr [0:7];
    int n_fail = 0, comparisons = 0, n_irq = 0, n;

    rx_packet_classifier_cam u_rx_packet_classifier_cam (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_rx_valid(v), .i_rx_sof(s), .i_rx_eof(e), .i_rx_data(d), .i_rule_wr(i_rule_wr),
        .i_rule_index_select(i_rule_index_select), .i_rule_match_word(i_rule_match_word),
        .i_rule_action_word(i_rule_action_word), .o_ready(o_ready), .o_frame_done(o_frame_done),
        .o_rx_packet_status_reg(o_rx_packet_status_reg), .o_drop(o_drop), .o_mcast(o_mcast),
        .o_bcast(o_bcast), .o_irq(o_irq), .o_host_notify_timer_start(o_host_notify_timer_start),
        .o_pause_value(o_pause_value), .o_pause_start(o_pause_start), .o_lentype_mark(o_lentype_mark),
        .o_iphdr_mark(o_iphdr_mark));
    rx_byte_source u_rx_byte_source (.i_core_clk(i_core_clk), .o_valid(v), .o_sof(s), .o_eof(e), .o_data(d));

    // 250 mhz clock
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // compare helpers
    task automatic check_val(input string nm, input logic [15:0] ex, input logic [15:0] got);
        comparisons++;
        if (got !== ex) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic check_frame(input logic [9:0] ex, input logic [9:0] got);
        check_val("bcast mcast drop result", {6'h00, ex}, {6'h00, got});
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one rule write, pulse for one cycle
    task automatic write_rule(input logic [6:0] idx, input logic [29:0] m, input logic [13:0] a);
        @(posedge i_core_clk);
        i_rule_wr <= 1'b1;
        i_rule_index_select <= idx;
        i_rule_match_word <= m;
        i_rule_action_word <= a;
        @(posedge i_core_clk);
        i_rule_wr <= 1'b0;
    endtask

    // queue the verdict, then send the frame and let it settle
    task automatic frame(input logic [6:0] res, input logic drp, input int len);
        exp_q.push_back({exp_mb, drp, res});
        u_rx_byte_source.send(fr, len);
        repeat (4) @(posedge i_core_clk);
    endtask

    // unicast filter 1 exact on bytes 0..5 of fr, byte 0 rule written first with previous hit ignored, rewritten last to need previous hit 0
    task automatic prog_filter1;
        logic [6:0] base [0:5];
        logic [6:0] prev;
        base = '{7'h70, 7'h68, 7'h58, 7'h50, 7'h40, 7'h30};
        prev = 7'h00;
        for (int k = 0; k < 6; k++) begin
            write_rule(base[k] + 7'h01, {(k == 0) ? 7'h00 : 7'h7f, 8'hff, prev, fr[k]},
                (k == 5) ? {2'b00, `ACT_KEEP_SCRATCH, 8'h00} : 14'h0000);
            prev = base[k] + 7'h01;
        end
        write_rule(7'h71, {7'h7f, 8'hff, 7'h00, fr[0]}, 14'h0000);
    endtask

    // result monitor: oldest expectation against each frame done
    always @(posedge i_core_clk) begin
        if (o_irq === 1'b1)
            n_irq <= n_irq + 1;
        // one nibble per pulse output: pause start, ip header, len/type, notify timer
        n_pulse <= n_pulse + {3'h0, o_pause_start === 1'b1, 3'h0, o_iphdr_mark === 1'b1,
            3'h0, o_lentype_mark === 1'b1, 3'h0, o_host_notify_timer_start === 1'b1};
        if (o_frame_done === 1'b1) begin
            if (exp_q.size() == 0)
                check_val("unexpected frame done", 16'h0000, 16'h0001);
            else
                check_frame(exp_q.pop_front(), {o_bcast, o_mcast, o_drop, o_rx_packet_status_reg});
        end
    end

    // main sequence
    initial begin
        i_rst = 1'b1;
        i_rule_wr = 1'b0;
        i_rule_index_select = 7'h00;
        i_rule_match_word = 30'h00000000;
        i_rule_action_word = 14'h0000;
        void'($urandom(88843));
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        n = 0;
        while (o_ready !== 1'b1 && n < 300) begin
            @(posedge i_core_clk);
            n++;
        end
        check_val("ready edges", 16'd129, n[15:0]);
        for (int i = 0; i < 8; i++)
            fr[i] = $urandom;
        fr[0][0] = 1'b0;
        frame(7'h30, 1'b0, 8);
        write_rule(7'h30, {7'h7f, 8'h00, 7'h40, 8'h00}, {`MC_DROP, 1'b0, `ACT_KEEP_SCRATCH, 8'h00});
        frame(7'h30, 1'b1, 6);
        prog_filter1;
        frame(7'h31, 1'b0, 7);
        fr[0][1] = ~fr[0][1];
        frame(7'h30, 1'b1, 6);
        write_rule(7'h30, {7'h7f, 8'h00, 7'h40, 8'h00}, {`MC_PASS_ON_MATCH, 1'b0, `ACT_KEEP_SCRATCH, 8'h00});
        frame(7'h30, 1'b0, 6);
        // byte 0 kept unicast so the group-bit filters cannot outrank entry 0x78
        write_rule(7'h78, {7'h7f, 8'hff, 7'h00, 8'h5a}, {`MC_PASS_ON_MATCH, 1'b1, `ACT_PAUSE_HI, 8'h00});
        fr[0] = 8'h5a;
        frame(7'h01, 1'b0, 2);
        check_val("pause high byte", 16'h005a, {8'h00, o_pause_value[15:8]});
        // default multicast filter 0 (group bit) and broadcast filter
        exp_mb = 2'b01;
        fr[0] = 8'h03;
        frame(7'h3c, 1'b0, 6);
        exp_mb = 2'b10;
        for (int i = 0; i < 6; i++)
            fr[i] = 8'hff;
        frame(7'h3f, 1'b0, 6);
        exp_mb = 2'b00;
        // loop of two: load tally, count down twice, then exit on previous hit 0x2a
        write_rule(7'h7b, {7'h7f, 8'hff, 7'h00, 8'h22}, {2'b00, `ACT_LOAD_LOOP_COUNT, 8'h02});
        // loop rule takes previous hit 0x7b or itself; entry 0x2a below it stays unused
        write_rule(7'h2b, {7'h2f, 8'h00, 7'h2b, 8'h00}, {2'b00, `ACT_LOOP_COUNT_DOWN, 8'h00});
        write_rule(7'h2c, {7'h7f, 8'h00, 7'h2a, 8'h00}, {2'b00, `ACT_DONE, 8'h00});
        fr[0] = 8'h22;
        frame(7'h2c, 1'b0, 5);
        // chain of action rules, one per byte
        for (int i = 1; i < 8; i++)
            fr[i] = $urandom;
        write_rule(7'h7a, {7'h7f, 8'hff, 7'h00, 8'h12}, {2'b00, `ACT_WAKE, 8'h00});
        write_rule(7'h2d, {7'h7f, 8'h00, 7'h7a, 8'h00}, {2'b00, `ACT_MARK_LENTYPE, 8'h00});
        write_rule(7'h2e, {7'h7f, 8'h00, 7'h2d, 8'h00}, {2'b00, `ACT_MARK_IPHDR, 8'h00});
        write_rule(7'h2f, {7'h7f, 8'h00, 7'h2e, 8'h00}, {2'b00, `ACT_PAUSE_LO, 8'h00});
        write_rule(7'h29, {7'h7f, 8'h00, 7'h2f, 8'h00}, {2'b00, `ACT_PAUSE_START, 8'h00});
        fr[0] = 8'h12;
        frame(7'h29, 1'b0, 5);
        check_val("pause value", {8'h5a, fr[3]}, o_pause_value);
        check_val("action pulses", 16'h1111, n_pulse);
        check_val("interrupts", 16'h0001, n_irq[15:0]);
        check_val("left over verdicts", 16'h0000, 16'(exp_q.size()));
        wrap_up();
    end

    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        #80000;
        n_fail++;
        wrap_up();
    end
endmodule // rx_packet_classifier_cam_tb
